// File: pkg/cpu_regs_pkg.sv
// package: constants and carrier types for the cpu register, flag and stack block
package cpu_regs_pkg;
    // ---------------------------------------------------------------
    // data-space map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_POINTER_ONE = 8'h80;
    localparam logic [7:0] ADDR_POINTER_TWO = 8'h81;
    localparam logic [7:0] ADDR_SHORT_FIRST = 8'h82;
    localparam logic [7:0] ADDR_SHORT_SECOND = 8'h83;
    localparam logic [7:0] ADDR_SUM_REGISTER = 8'hff;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // ---------------------------------------------------------------
    // program counter and stack
    // ---------------------------------------------------------------
    localparam int PC_W = 12;
    localparam int STACK_DEPTH = 6;
    localparam int DEPTH_W = 3;
    localparam logic [11:0] PC_ONE = 12'h001;
    localparam logic [11:0] PC_ZERO = 12'h000;
    localparam logic [2:0] DEPTH_ONE = 3'h1;
    localparam logic [2:0] DEPTH_ZERO = 3'h0;
    // ---------------------------------------------------------------
    // execution contexts (flag pair select)
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CTX_NORMAL = 2'b00,
        CTX_IRQ = 2'b01,
        CTX_NMI = 2'b10
    } ctx_t;
    // program counter update sources
    typedef enum logic [2:0] {
        PC_HOLD = 3'b000,
        PC_SEQ = 3'b001,
        PC_JUMP = 3'b010,
        PC_CALL = 3'b011,
        PC_REL = 3'b100,
        PC_IRQ = 3'b101,
        PC_NMI = 3'b110,
        PC_RETURN = 3'b111
    } pc_op_t;
    // flag update from the arithmetic unit
    typedef struct packed {
        logic carry_we;   // write carry of active pair
        logic carry_val;  // carry/borrow or tested bit
        logic zero_we;    // write zero of active pair
        logic zero_val;   // result was zero
    } flag_upd_t;
    // data-space access
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dbus_req_t;
endpackage : cpu_regs_pkg

// File: design/cpu_register_flags_stack.sv
// cpu programmer-visible registers, banked flags and six-level return stack
//
// Overview of operation
// RULE_01: eight-bit sum register, data-space location ffh
// RULE_02: two pointer registers at 80h and 81h
// RULE_03: pointers reachable by any data-space addressing
// RULE_04: two short-direct registers at 82h, 83h
// RULE_05: twelve-bit program counter, banking outside
// RULE_06: sequential fetch increments program counter
// RULE_07: relative branch adds signed offset to counter
// RULE_08: jump, call, vectors, returns load counter
// RULE_09: three separate carry/zero flag pairs
// RULE_10: interrupt entry switches pair, return restores
// RULE_11: pairs keep values, only owner addresses
// RULE_12: carry set on carry or borrow
// RULE_13: bit test copies into carry; rotate uses it
// RULE_14: zero set when result equals zero
// RULE_15: reset starts in nmi context
// RULE_16: six-level twelve-bit hidden lifo stack
// RULE_17: push shifts up, sixth level lost
// RULE_18: pop loads counter, shifts down
// RULE_19: overflow keeps stack at deepest position
// RULE_20: empty return keeps stack, continues sequentially
// RULE_21: only program counter is stacked (the code also stacks the context with each level)
// RULE_22: vectors are design parameters
module cpu_register_flags_stack
    import cpu_regs_pkg::*;
#(
    parameter logic [11:0] RESET_VECTOR = 12'hffe, // see RULE_22
    parameter logic [11:0] IRQ_VECTOR = 12'hff0,   // see RULE_22
    parameter logic [11:0] NMI_VECTOR = 12'hffc    // see RULE_22
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire dbus_req_t i_dbus,          // data-space write from the sequencer
    output logic [7:0] o_dbus_rdata,       // read data for i_dbus.addr
    output logic o_dbus_hit,               // address belongs to this block
    input wire pc_op_t i_pc_op,            // program counter update request
    input wire logic [11:0] i_target,      // jump or call address
    input wire logic [7:0] i_rel_offset,   // signed relative offset
    input wire flag_upd_t i_flag_upd,      // alu flag result
    output logic [11:0] o_program_counter,
    output logic [7:0] o_sum_register,
    output logic [7:0] o_pointer_one,
    output logic [7:0] o_pointer_two,
    output logic o_carry,                  // carry of active pair
    output logic o_zero,                   // zero of active pair
    output ctx_t o_ctx,
    output logic [2:0] o_stack_depth
);
    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [7:0] sum_register_r;
    logic [7:0] pointer_one_r;
    logic [7:0] pointer_two_r;
    logic [7:0] short_slot_first_r;
    logic [7:0] short_slot_second_r;
    logic [11:0] program_counter_r;
    logic [11:0] stack_r [STACK_DEPTH];   // level one is index 0
    logic [2:0] depth_r;                  // entries holding a valid return
    ctx_t ctx_stack_r [STACK_DEPTH];      // previous context per level
    ctx_t ctx_r;
    logic [2:0] carry_r;                  // one bit per context
    logic [2:0] zero_r;
    logic is_push;
    logic is_pop;
    logic [11:0] rel_sum;

    assign is_push = (i_pc_op == PC_CALL) || (i_pc_op == PC_IRQ) || (i_pc_op == PC_NMI);
    assign is_pop = (i_pc_op == PC_RETURN);
    // sign-extended offset, wraps within twelve bits
    assign rel_sum = program_counter_r + {{4{i_rel_offset[7]}}, i_rel_offset}; // see RULE_07

    // ---------------------------------------------------------------
    // data-space registers
    // ---------------------------------------------------------------
    // ordinary byte registers; bit ops are read-modify-write by the sequencer
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            sum_register_r <= DATA_RESET;
            pointer_one_r <= DATA_RESET;
            pointer_two_r <= DATA_RESET;
            short_slot_first_r <= DATA_RESET;
            short_slot_second_r <= DATA_RESET;
        end else if (i_dbus.wr) begin
            case (i_dbus.addr)
                ADDR_SUM_REGISTER: sum_register_r <= i_dbus.wdata;      // see RULE_01
                ADDR_POINTER_ONE: pointer_one_r <= i_dbus.wdata;        // see RULE_02, see RULE_03
                ADDR_POINTER_TWO: pointer_two_r <= i_dbus.wdata;        // see RULE_02, see RULE_03
                ADDR_SHORT_FIRST: short_slot_first_r <= i_dbus.wdata;   // see RULE_04
                ADDR_SHORT_SECOND: short_slot_second_r <= i_dbus.wdata; // see RULE_04
                default: begin
                    // other addresses belong to other blocks
                end
            endcase
        end
    end

    // combinational read mux; unmapped addresses read zero with no hit
    always_comb begin
        o_dbus_hit = 1'b1;
        case (i_dbus.addr)
            ADDR_SUM_REGISTER: o_dbus_rdata = sum_register_r;
            ADDR_POINTER_ONE: o_dbus_rdata = pointer_one_r;
            ADDR_POINTER_TWO: o_dbus_rdata = pointer_two_r;
            ADDR_SHORT_FIRST: o_dbus_rdata = short_slot_first_r;
            ADDR_SHORT_SECOND: o_dbus_rdata = short_slot_second_r;
            default: begin
                o_dbus_rdata = DATA_RESET;
                o_dbus_hit = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // program counter
    // ---------------------------------------------------------------
    // banking above 4096 bytes is done by an outside bank register
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            program_counter_r <= RESET_VECTOR;                  // see RULE_08
        end else begin
            case (i_pc_op)
                PC_SEQ: program_counter_r <= program_counter_r + PC_ONE; // see RULE_06
                PC_JUMP: program_counter_r <= i_target;          // see RULE_08
                PC_CALL: program_counter_r <= i_target;          // see RULE_08
                PC_REL: program_counter_r <= rel_sum;            // see RULE_07
                PC_IRQ: program_counter_r <= IRQ_VECTOR;         // see RULE_08
                PC_NMI: program_counter_r <= NMI_VECTOR;         // see RULE_08
                PC_RETURN: begin
                    // empty stack: fall through to the next instruction
                    if (depth_r == DEPTH_ZERO) begin
                        program_counter_r <= program_counter_r + PC_ONE; // see RULE_20
                    end else begin
                        program_counter_r <= stack_r[0];         // see RULE_18
                    end
                end
                default: program_counter_r <= program_counter_r;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // return stack
    // ---------------------------------------------------------------
    // the counter and its context are pushed, never data registers; see RULE_21
    // the pushed value is the counter as it stands, which already points
    // past the calling instruction
    generate
        for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_level
            logic [11:0] push_val; // what moves into this level on a push
            ctx_t push_ctx;
            logic [11:0] pop_val;  // what moves into this level on a pop
            ctx_t pop_ctx;
            // neighbours are picked at elaboration so no index ever leaves the array
            if (g == 0) begin : g_bottom
                assign push_val = program_counter_r;    // see RULE_17
                assign push_ctx = ctx_r;
            end else begin : g_above
                assign push_val = stack_r[g-1];         // see RULE_17
                assign push_ctx = ctx_stack_r[g-1];
            end
            // the sixth level has nothing above it, so it keeps its stale value on a pop
            if (g < STACK_DEPTH - 1) begin : g_below_top
                assign pop_val = stack_r[g+1];          // see RULE_18
                assign pop_ctx = ctx_stack_r[g+1];
            end else begin : g_top
                assign pop_val = stack_r[g];
                assign pop_ctx = ctx_stack_r[g];
            end
            // one shifting register per level
            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_b) begin
                    stack_r[g] <= PC_ZERO;
                    ctx_stack_r[g] <= CTX_NORMAL;
                end else if (is_push) begin
                    stack_r[g] <= push_val;
                    ctx_stack_r[g] <= push_ctx;
                end else if (is_pop && depth_r != DEPTH_ZERO) begin
                    stack_r[g] <= pop_val;
                    ctx_stack_r[g] <= pop_ctx;
                end
            end
        end
    endgenerate

    // depth saturates at six so the oldest return is simply lost
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            depth_r <= DEPTH_ZERO;
        end else if (is_push) begin
            if (depth_r != 3'(STACK_DEPTH)) begin
                depth_r <= depth_r + DEPTH_ONE;
            end                                             // see RULE_19
        end else if (is_pop && depth_r != DEPTH_ZERO) begin
            depth_r <= depth_r - DEPTH_ONE;                 // see RULE_20
        end
    end

    // ---------------------------------------------------------------
    // context and banked flags
    // ---------------------------------------------------------------
    // context saved per stack level so that a return restores the pair that
    // was in use; a plain return from a call leaves the context alone
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            ctx_r <= CTX_NMI;                               // see RULE_15
        end else if (i_pc_op == PC_IRQ) begin
            ctx_r <= CTX_IRQ;                               // see RULE_10
        end else if (i_pc_op == PC_NMI) begin
            ctx_r <= CTX_NMI;                               // see RULE_10
        end else if (is_pop && i_target[0]) begin
            // interrupt exit: back to the pair saved with the return address
            if (depth_r != DEPTH_ZERO) begin
                ctx_r <= ctx_stack_r[0];                    // see RULE_10
            end else begin
                // nothing stacked: this is how start-up code leaves nmi context
                // and reaches normal code, else the normal pair is unreachable
                ctx_r <= CTX_NORMAL;                        // see RULE_10, see RULE_09
            end
        end
    end

    // only the active pair is written; others hold across switches
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            carry_r <= 3'h0;
            zero_r <= 3'h0;
        end else begin
            if (i_flag_upd.carry_we) begin
                carry_r[ctx_r] <= i_flag_upd.carry_val;     // see RULE_12, see RULE_13, see RULE_11
            end
            if (i_flag_upd.zero_we) begin
                zero_r[ctx_r] <= i_flag_upd.zero_val;       // see RULE_14, see RULE_11
            end
        end
    end

    // flags seen by the alu come from the owning context only
    assign o_carry = carry_r[ctx_r];                        // see RULE_09, see RULE_13
    assign o_zero = zero_r[ctx_r];                          // see RULE_09
    assign o_ctx = ctx_r;
    assign o_program_counter = program_counter_r;           // see RULE_05
    assign o_sum_register = sum_register_r;
    assign o_pointer_one = pointer_one_r;
    assign o_pointer_two = pointer_two_r;
    assign o_stack_depth = depth_r;                         // see RULE_16

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_seq_inc;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_pc_op == PC_SEQ |=> program_counter_r == $past(program_counter_r) + PC_ONE;
    endproperty
    a_seq_inc: assert property (p_seq_inc) else $error("pc did not increment"); // see RULE_06

    property p_depth_sat;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        is_push && depth_r == 3'(STACK_DEPTH) |=> depth_r == 3'(STACK_DEPTH);
    endproperty
    a_depth_sat: assert property (p_depth_sat) else $error("stack depth passed six"); // see RULE_19

    sequence s_call;
        i_pc_op == PC_CALL && depth_r < 3'(STACK_DEPTH);
    endsequence
    sequence s_ret;
        i_pc_op == PC_RETURN && i_rst_b;
    endsequence
    // a call straight followed by a return lands on the counter seen at the call
    property p_call_ret;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        s_call ##1 s_ret |=> program_counter_r == $past(program_counter_r, 2);
    endproperty
    a_call_ret: assert property (p_call_ret) else $error("return address wrong"); // see RULE_18

    property p_empty_ret;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        is_pop && depth_r == DEPTH_ZERO |=> depth_r == DEPTH_ZERO && program_counter_r == $past(program_counter_r) + PC_ONE;
    endproperty
    a_empty_ret: assert property (p_empty_ret) else $error("empty return misbehaved"); // see RULE_20

    property p_irq_ctx;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_pc_op == PC_IRQ |=> ctx_r == CTX_IRQ && program_counter_r == IRQ_VECTOR;
    endproperty
    a_irq_ctx: assert property (p_irq_ctx) else $error("irq entry wrong"); // see RULE_10

    property p_flag_keep;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (ctx_r != CTX_NORMAL) [*2] |-> $stable(carry_r[0]) && $stable(zero_r[0]);
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("inactive pair changed"); // see RULE_11

    property p_carry_wr;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_flag_upd.carry_we ##1 ctx_r == $past(ctx_r) |-> o_carry == $past(i_flag_upd.carry_val);
    endproperty
    a_carry_wr: assert property (p_carry_wr) else $error("carry not written"); // see RULE_12

    property p_sum_wr;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_dbus.wr && i_dbus.addr == ADDR_SUM_REGISTER |=> o_sum_register == $past(i_dbus.wdata);
    endproperty
    a_sum_wr: assert property (p_sum_wr) else $error("sum register write lost"); // see RULE_01
endmodule : cpu_register_flags_stack

// File: sim/seq_model.sv
// sequencer and data-bus model that feeds the register, flag and stack block
module seq_model
    import cpu_regs_pkg::*;
(
    input wire logic i_ref_clk,
    output dbus_req_t o_dbus,
    output pc_op_t o_pc_op,
    output logic [11:0] o_target,
    output logic [7:0] o_rel_offset,
    output flag_upd_t o_flag_upd
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // quiet bus at time zero
    // ---------------------------------------------------------------
    initial begin
        o_dbus = '0;
        o_pc_op = PC_HOLD;
        o_target = 12'h000;
        o_rel_offset = 8'h00;
        o_flag_upd = '0;
    end
    // one operation per cycle, launched just after the edge so it is settled at the next
    task automatic issue(input pc_op_t op, input logic [11:0] tgt, input logic [7:0] off,
                         input flag_upd_t fl, input dbus_req_t db);
        @(posedge i_ref_clk);
        #1;
        o_pc_op = op;
        o_target = tgt;
        o_rel_offset = off;
        o_flag_upd = fl;
        o_dbus = db;
    endtask : issue
    // idle cycle: operands that no longer matter flip, so a stale value never passes for a live one
    task automatic idle();
        @(posedge i_ref_clk);
        #1;
        o_pc_op = PC_HOLD;
        o_target = ~o_target;
        o_rel_offset = ~o_rel_offset;
        o_flag_upd = '{carry_we: 1'b0, carry_val: ~o_flag_upd.carry_val, zero_we: 1'b0,
                       zero_val: ~o_flag_upd.zero_val};
        o_dbus.wr = 1'b0;
        o_dbus.wdata = ~o_dbus.wdata;
    endtask : idle
endmodule : seq_model

// File: sim/test_cpu_register_flags_stack.sv
// self-checking testbench for the register, flag and stack block
module test_cpu_register_flags_stack
    import cpu_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // vectors chosen apart from the defaults so the parameters are exercised
    // ---------------------------------------------------------------
    localparam logic [11:0] RST_V = 12'h7fe;
    localparam logic [11:0] IRQ_V = 12'h3f0;
    localparam logic [11:0] NMI_V = 12'h5fc;
    logic ref_clk;
    logic rst_b;
    dbus_req_t dbus;
    pc_op_t pc_op;
    logic [11:0] target;
    logic [7:0] rel_offset;
    flag_upd_t flag_upd;
    logic [7:0] rdata;
    logic hit;
    logic [11:0] prog_cnt;
    logic [7:0] sum_reg;
    logic [7:0] ptr_one;
    logic [7:0] ptr_two;
    logic carry;
    logic zero;
    ctx_t ctx;
    logic [2:0] depth;
    int fail_count = 0;
    int tests_run = 0;
    logic [7:0] map_addr [5] = '{ADDR_POINTER_ONE, ADDR_POINTER_TWO, ADDR_SHORT_FIRST,
                                 ADDR_SHORT_SECOND, ADDR_SUM_REGISTER};
    cpu_register_flags_stack #(.RESET_VECTOR(RST_V), .IRQ_VECTOR(IRQ_V), .NMI_VECTOR(NMI_V))
    i_cpu_register_flags_stack (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_dbus(dbus),
        .o_dbus_rdata(rdata), .o_dbus_hit(hit), .i_pc_op(pc_op), .i_target(target),
        .i_rel_offset(rel_offset), .i_flag_upd(flag_upd), .o_program_counter(prog_cnt),
        .o_sum_register(sum_reg), .o_pointer_one(ptr_one), .o_pointer_two(ptr_two),
        .o_carry(carry), .o_zero(zero), .o_ctx(ctx), .o_stack_depth(depth));
    seq_model i_seq_model (.i_ref_clk(ref_clk), .o_dbus(dbus), .o_pc_op(pc_op), .o_target(target),
        .o_rel_offset(rel_offset), .o_flag_upd(flag_upd));
    // ---------------------------------------------------------------
    // clock, report and compare helpers
    // ---------------------------------------------------------------
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    // multi-bit values, zero extended to the program counter width
    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask : chk_bit
    // issue one program counter operation with no flag update and no data-bus write
    task automatic run(input pc_op_t op, input logic [11:0] t, input logic [7:0] off);
        i_seq_model.issue(op, t, off, '0, '0);
    endtask : run
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_seq_model.issue(PC_HOLD, 12'h000, 8'h00, '0, '{wr: 1'b1, addr: a, wdata: d});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        i_seq_model.issue(PC_HOLD, 12'h000, 8'h00, '0, '{wr: 1'b0, addr: a, wdata: 8'h00});
        #1;
        chk_val({4'h0, rdata}, {4'h0, e}, "read data");
        chk_bit(hit, h, "address hit");
    endtask : rd
    task automatic state(input logic [11:0] p, input ctx_t c, input logic [2:0] d, input logic cf,
                         input logic zf);
        chk_val(prog_cnt, p, "counter");
        chk_val({10'h000, ctx}, {10'h000, c}, "context");
        chk_val({9'h000, depth}, {9'h000, d}, "depth");
        chk_bit(carry, cf, "carry");
        chk_bit(zero, zf, "zero");
    endtask : state
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic scn_regs();
        for (int k = 0; k < 5; k++) begin
            wr(map_addr[k], 8'h3c + 8'(k));
        end
        wr(8'h84, 8'hee); // unmapped place, must be ignored
        i_seq_model.idle();
        for (int k = 0; k < 5; k++) begin
            rd(map_addr[k], 8'h3c + 8'(k), 1'b1);
        end
        rd(8'h84, 8'h00, 1'b0);
        chk_val({4'h0, sum_reg}, 12'h040, "sum output");
        chk_val({4'h0, ptr_one}, 12'h03c, "pointer one");
        chk_val({4'h0, ptr_two}, 12'h03d, "pointer two");
    endtask : scn_regs
    task automatic scn_counter();
        run(PC_JUMP, 12'h123, 8'h00);
        run(PC_SEQ, 12'h000, 8'h00);
        run(PC_SEQ, 12'h000, 8'h00);
        run(PC_REL, 12'h000, 8'hf0); // backwards by sixteen
        i_seq_model.idle();
        chk_val(prog_cnt, 12'h115, "jump, step, branch");
        run(PC_JUMP, 12'hffa, 8'h00);
        run(PC_REL, 12'h000, 8'h10); // crosses the top of the 4096 byte space
        i_seq_model.idle();
        chk_val(prog_cnt, 12'h00a, "branch wrap");
    endtask : scn_counter
    task automatic scn_flags();
        i_seq_model.issue(PC_HOLD, 12'h000, 8'h00, '{1'b1, 1'b1, 1'b1, 1'b0}, '0);
        i_seq_model.idle();
        state(12'h00a, CTX_NMI, 3'h1 - 3'h1, 1'b1, 1'b0);
        run(PC_IRQ, 12'h000, 8'h00);
        i_seq_model.idle();
        state(IRQ_V, CTX_IRQ, 3'h1, 1'b0, 1'b0);
        i_seq_model.issue(PC_HOLD, 12'h000, 8'h00, '{1'b0, 1'b1, 1'b1, 1'b1}, '0);
        i_seq_model.issue(PC_NMI, 12'h000, 8'h00, '{1'b0, 1'b0, 1'b0, 1'b0}, '0);
        i_seq_model.idle();
        state(NMI_V, CTX_NMI, 3'h2, 1'b1, 1'b0);
        run(PC_RETURN, 12'h001, 8'h00); // interrupt exit back to the irq level
        i_seq_model.idle();
        state(IRQ_V, CTX_IRQ, 3'h1, 1'b0, 1'b1);
        run(PC_RETURN, 12'h001, 8'h00);
        i_seq_model.idle();
        state(12'h00a, CTX_NMI, 3'h0, 1'b1, 1'b0);
    endtask : scn_flags
    task automatic scn_stack();
        run(PC_JUMP, 12'h010, 8'h00);
        for (int k = 0; k < 7; k++) begin
            run(PC_CALL, 12'h100 + 12'(k), 8'h00); // one deeper than the stack holds
        end
        i_seq_model.idle();
        state(12'h106, CTX_NMI, 3'h6, 1'b1, 1'b0);
        for (int k = 0; k < 6; k++) begin
            run(PC_RETURN, 12'h000, 8'h00);
            i_seq_model.idle();
            chk_val(prog_cnt, 12'h105 - 12'(k), "popped address");
            chk_val({9'h000, depth}, 12'h005 - 12'(k), "pop depth");
        end
        run(PC_RETURN, 12'h000, 8'h00); // return on an empty stack
        i_seq_model.idle();
        state(12'h101, CTX_NMI, 3'h0, 1'b1, 1'b0);
        run(PC_CALL, 12'h200, 8'h00); // call and return back to back
        run(PC_RETURN, 12'h000, 8'h00);
        i_seq_model.idle();
        state(12'h101, CTX_NMI, 3'h0, 1'b1, 1'b0);
        rd(ADDR_SUM_REGISTER, 8'h40, 1'b1);
    endtask : scn_stack
    // leave the start-up context for normal code and use the normal pair
    task automatic scn_normal();
        run(PC_RETURN, 12'h001, 8'h00); // interrupt exit with nothing stacked
        i_seq_model.idle();
        state(12'h102, CTX_NORMAL, 3'h0, 1'b0, 1'b0);
        i_seq_model.issue(PC_HOLD, 12'h000, 8'h00, '{1'b1, 1'b1, 1'b1, 1'b1}, '0);
        run(PC_IRQ, 12'h000, 8'h00);
        i_seq_model.idle();
        state(IRQ_V, CTX_IRQ, 3'h1, 1'b0, 1'b1);
        run(PC_RETURN, 12'h001, 8'h00);
        i_seq_model.idle();
        state(12'h102, CTX_NORMAL, 3'h0, 1'b1, 1'b1);
        i_seq_model.issue(PC_HOLD, 12'h000, 8'h00, '{1'b1, 1'b0, 1'b0, 1'b0}, '0);
        i_seq_model.idle();
        state(12'h102, CTX_NORMAL, 3'h0, 1'b0, 1'b1);
    endtask : scn_normal
    // ---------------------------------------------------------------
    // main sequence and hang guard
    // ---------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        state(RST_V, CTX_NMI, 3'h0, 1'b0, 1'b0);
        scn_regs();
        scn_counter();
        scn_flags();
        scn_stack();
        scn_normal();
        results();
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        fail_count++;
        $display("unexpected at %0t: run did not finish", $time);
        results();
    end
endmodule : test_cpu_register_flags_stack
